// ### tfs_pkg.sv
// shared constants, types and helpers for the transmit slot state control
package tfs_pkg;
    localparam int unsigned RTC_W = 4;
    localparam int unsigned MEM_AW = 4;
    localparam int unsigned MEM_WORDS = 16;
    localparam int unsigned ST_W = 3;

    // apb register byte offsets
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_MEM = 8'h40;
    localparam logic [7:0] MEM_MASK = 8'hc0;

    // command register bits
    localparam int unsigned CMD_READY = 0;
    localparam int unsigned CMD_ABORT = 1;
    localparam int unsigned CMD_EMPTY = 2;

    // config register fields
    localparam int unsigned CFG_LIM_LSB = 0;
    localparam int unsigned CFG_EN_BIT = 8;
    localparam logic [RTC_W-1:0] LIM_RST = 4'h0;

    // status register fields
    localparam int unsigned STAT_ST_LSB = 0;
    localparam int unsigned STAT_CNT_LSB = 8;

    typedef enum logic [ST_W-1:0] {
        ST_EMPTY, ST_READY, ST_TX, ST_ABT_PEND, ST_TX_OK, ST_ABORTED, ST_FAILED
    } tfs_state_t;

    typedef enum logic [1:0] {C_IDLE, C_VALID, C_TX} tfs_ctl_t;

    // frame memory is locked against software writes in these states
    function automatic logic is_locked(input tfs_state_t s);
        return (s == ST_READY) || (s == ST_TX) || (s == ST_ABT_PEND);
    endfunction

    // attempt budget used up: limit enabled and counter at the limit
    function automatic logic retry_spent(input logic [RTC_W-1:0] cnt,
                                         input logic [RTC_W-1:0] lim,
                                         input logic en);
        return en && (cnt == lim);
    endfunction
endpackage

// ### tfs_link_if.sv
// link between the transmit slot and the protocol controller
`timescale 1ns/100ps
interface tfs_link_if;
    logic avail;
    logic lock;
    logic unl_done;
    logic unl_err;
    logic unl_arbl;
    logic unl_fail;
    logic [tfs_pkg::RTC_W-1:0] rtc_cnt;
    logic [tfs_pkg::RTC_W-1:0] rtc_lim;
    logic rtc_en;
    logic [tfs_pkg::MEM_AW-1:0] rd_addr;
    logic [31:0] rd_data;

    modport slot (output avail, rtc_cnt, rtc_lim, rtc_en, rd_data,
                  input lock, unl_done, unl_err, unl_arbl, unl_fail, rd_addr);
    modport ctl (input avail, rtc_cnt, rtc_lim, rtc_en, rd_data,
                 output lock, unl_done, unl_err, unl_arbl, unl_fail, rd_addr);
endinterface

// ### tfs_rtc.sv
// retransmission counter of the slot
`timescale 1ns/100ps
module tfs_rtc (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clr,
    input wire logic inc,
    output logic [tfs_pkg::RTC_W-1:0] cnt
);
    logic [tfs_pkg::RTC_W-1:0] cnt_r;
    logic [tfs_pkg::RTC_W-1:0] cnt_nxt;

    // clear on a new frame, otherwise step by one per failed attempt
    always_comb begin
        cnt_nxt = cnt_r;
        if (clr) begin
            cnt_nxt = '0;
        end else if (inc) begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
        end
    end

    assign cnt = cnt_r;
endmodule

// ### tfs_slot.sv
// transmit frame slot: state machine, frame memory and apb registers
`timescale 1ns/100ps
module tfs_slot (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [tfs_pkg::ST_W-1:0] SLOT_STATE,
    tfs_link_if.slot lnk
);
    tfs_pkg::tfs_state_t st_r;
    tfs_pkg::tfs_state_t st_nxt;
    logic [31:0] mem [tfs_pkg::MEM_WORDS];
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [tfs_pkg::RTC_W-1:0] lim_r;
    logic [tfs_pkg::RTC_W-1:0] lim_nxt;
    logic en_r;
    logic en_nxt;
    logic avail_r;
    logic avail_nxt;
    logic [tfs_pkg::RTC_W-1:0] cnt;
    logic acc;
    logic wr;
    logic hit_cmd;
    logic hit_cfg;
    logic hit_stat;
    logic hit_mem;
    logic sw_ready;
    logic sw_abort;
    logic sw_empty;
    logic rtc_clr;
    logic rtc_inc;
    logic mem_we;
    logic [tfs_pkg::MEM_AW-1:0] mem_idx;

    // apb decode: transfer completes when our registered pready is seen
    assign acc = PSEL && PENABLE && pready_r;
    assign wr = acc && PWRITE;
    assign hit_cmd = PADDR == tfs_pkg::OFF_CMD;
    assign hit_cfg = PADDR == tfs_pkg::OFF_CFG;
    assign hit_stat = PADDR == tfs_pkg::OFF_STAT;
    assign hit_mem = ((PADDR & tfs_pkg::MEM_MASK) == tfs_pkg::OFF_MEM) && (PADDR[1:0] == 2'b00);
    assign mem_idx = PADDR[tfs_pkg::MEM_AW+1:2];

    // software command pulses, one per completed write
    assign sw_ready = wr && hit_cmd && PWDATA[tfs_pkg::CMD_READY];
    assign sw_abort = wr && hit_cmd && PWDATA[tfs_pkg::CMD_ABORT];
    assign sw_empty = wr && hit_cmd && PWDATA[tfs_pkg::CMD_EMPTY];
    assign mem_we = CE && wr && hit_mem && !tfs_pkg::is_locked(st_r);

    // apb answer: one wait cycle, then pready with data and error
    always_comb begin
        pready_nxt = PSEL && PENABLE && !pready_r;
        prdata_nxt = '0;
        pslverr_nxt = 1'b0;
        if (pready_nxt) begin
            pslverr_nxt = !(hit_cmd || hit_cfg || hit_stat || hit_mem);
            if (hit_cfg) begin
                prdata_nxt[tfs_pkg::CFG_LIM_LSB +: tfs_pkg::RTC_W] = lim_r;
                prdata_nxt[tfs_pkg::CFG_EN_BIT] = en_r;
            end else if (hit_stat) begin
                prdata_nxt[tfs_pkg::STAT_ST_LSB +: tfs_pkg::ST_W] = st_r;
                prdata_nxt[tfs_pkg::STAT_CNT_LSB +: tfs_pkg::RTC_W] = cnt;
            end
        end
    end

    // retry limit and its enable
    always_comb begin
        lim_nxt = lim_r;
        en_nxt = en_r;
        if (wr && hit_cfg) begin
            lim_nxt = PWDATA[tfs_pkg::CFG_LIM_LSB +: tfs_pkg::RTC_W];
            en_nxt = PWDATA[tfs_pkg::CFG_EN_BIT];
        end
    end

    // slot state machine; software abort wins over error and lost outcomes
    always_comb begin
        st_nxt = st_r;
        rtc_clr = 1'b0;
        rtc_inc = 1'b0;
        unique case (st_r)
            tfs_pkg::ST_EMPTY: begin
                if (sw_ready) begin
                    st_nxt = tfs_pkg::ST_READY;
                    rtc_clr = 1'b1;
                end
            end
            tfs_pkg::ST_READY: begin
                if (lnk.lock && sw_abort) begin
                    st_nxt = tfs_pkg::ST_ABT_PEND;
                end else if (lnk.lock) begin
                    st_nxt = tfs_pkg::ST_TX;
                end else if (sw_abort) begin
                    st_nxt = tfs_pkg::ST_ABORTED;
                end
            end
            tfs_pkg::ST_TX: begin
                if (lnk.unl_done) begin
                    st_nxt = tfs_pkg::ST_TX_OK;
                end else if (lnk.unl_fail) begin
                    st_nxt = tfs_pkg::ST_FAILED;
                end else if (lnk.unl_err || lnk.unl_arbl) begin
                    st_nxt = sw_abort ? tfs_pkg::ST_ABORTED : tfs_pkg::ST_READY;
                    rtc_inc = !sw_abort;
                end else if (sw_abort) begin
                    st_nxt = tfs_pkg::ST_ABT_PEND;
                end
            end
            tfs_pkg::ST_ABT_PEND: begin
                if (lnk.unl_done) begin
                    st_nxt = tfs_pkg::ST_TX_OK;
                end else if (lnk.unl_fail) begin
                    st_nxt = tfs_pkg::ST_FAILED;
                end else if (lnk.unl_err || lnk.unl_arbl) begin
                    st_nxt = tfs_pkg::ST_ABORTED;
                end
            end
            tfs_pkg::ST_TX_OK, tfs_pkg::ST_ABORTED, tfs_pkg::ST_FAILED: begin
                if (sw_ready) begin
                    st_nxt = tfs_pkg::ST_READY;
                    rtc_clr = 1'b1;
                end else if (sw_empty) begin
                    st_nxt = tfs_pkg::ST_EMPTY;
                end
            end
            default: begin
                st_nxt = tfs_pkg::ST_EMPTY;
            end
        endcase
        avail_nxt = st_nxt == tfs_pkg::ST_READY;
    end

    // registers of the slot and the apb slave
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            st_r <= tfs_pkg::ST_EMPTY;
            avail_r <= 1'b0;
            pready_r <= 1'b0;
            prdata_r <= '0;
            pslverr_r <= 1'b0;
            lim_r <= tfs_pkg::LIM_RST;
            en_r <= 1'b0;
        end else if (CE) begin
            st_r <= st_nxt;
            avail_r <= avail_nxt;
            pready_r <= pready_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            lim_r <= lim_nxt;
            en_r <= en_nxt;
        end
    end

    // frame memory, written by software while unlocked
    always_ff @(posedge SYS_CLK) begin
        if (mem_we) begin
            mem[mem_idx] <= PWDATA;
        end
    end

    tfs_rtc u_rtc (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .ce(CE),
        .clr(rtc_clr),
        .inc(rtc_inc),
        .cnt(cnt)
    );

    // abort drops availability in the very cycle it is written
    assign lnk.avail = avail_r && !sw_abort;
    assign lnk.rtc_cnt = cnt;
    assign lnk.rtc_lim = lim_r;
    assign lnk.rtc_en = en_r;
    assign lnk.rd_data = mem[lnk.rd_addr];
    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign SLOT_STATE = st_r;
endmodule

// ### tfs_ctl.sv
// protocol controller end: validates, locks and unlocks the slot
`timescale 1ns/100ps
module tfs_ctl (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic LOCK_WINDOW,
    input wire logic FRAME_DONE,
    input wire logic FRAME_ERR,
    input wire logic ARB_LOST,
    input wire logic NEXT_WORD,
    output logic SLOT_VALID,
    output logic TX_ACTIVE,
    output logic [31:0] TX_WORD,
    tfs_link_if.ctl lnk
);
    tfs_pkg::tfs_ctl_t st_r;
    tfs_pkg::tfs_ctl_t st_nxt;
    logic lock_r;
    logic lock_nxt;
    logic done_r;
    logic done_nxt;
    logic err_r;
    logic err_nxt;
    logic arbl_r;
    logic arbl_nxt;
    logic fail_r;
    logic fail_nxt;
    logic [tfs_pkg::MEM_AW-1:0] addr_r;
    logic [tfs_pkg::MEM_AW-1:0] addr_nxt;
    logic [31:0] word_r;
    logic [31:0] word_nxt;
    logic valid_r;
    logic valid_nxt;
    logic act_r;
    logic act_nxt;
    logic spent;

    assign spent = tfs_pkg::retry_spent(lnk.rtc_cnt, lnk.rtc_lim, lnk.rtc_en);

    // validate, lock in the permitted window, then unlock with the outcome
    always_comb begin
        st_nxt = st_r;
        lock_nxt = 1'b0;
        done_nxt = 1'b0;
        err_nxt = 1'b0;
        arbl_nxt = 1'b0;
        fail_nxt = 1'b0;
        addr_nxt = addr_r;
        word_nxt = word_r;
        unique case (st_r)
            tfs_pkg::C_IDLE: begin
                if (lnk.avail) begin
                    st_nxt = tfs_pkg::C_VALID;
                end
            end
            tfs_pkg::C_VALID: begin
                if (!lnk.avail) begin
                    st_nxt = tfs_pkg::C_IDLE;
                end else if (LOCK_WINDOW) begin
                    st_nxt = tfs_pkg::C_TX;
                    lock_nxt = 1'b1;
                    addr_nxt = '0;
                end
            end
            tfs_pkg::C_TX: begin
                if (NEXT_WORD) begin
                    word_nxt = lnk.rd_data;
                    addr_nxt = addr_r + 1'b1;
                end
                if (FRAME_DONE) begin
                    st_nxt = tfs_pkg::C_IDLE;
                    done_nxt = 1'b1;
                end else if (FRAME_ERR || ARB_LOST) begin
                    st_nxt = tfs_pkg::C_IDLE;
                    fail_nxt = spent;
                    err_nxt = FRAME_ERR && !spent;
                    arbl_nxt = !FRAME_ERR && !spent;
                end
            end
            default: begin
                st_nxt = tfs_pkg::C_IDLE;
            end
        endcase
        // status outputs follow the next state so that they leave flops
        valid_nxt = st_nxt == tfs_pkg::C_VALID;
        act_nxt = st_nxt == tfs_pkg::C_TX;
    end

    // controller registers
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            st_r <= tfs_pkg::C_IDLE;
            lock_r <= 1'b0;
            done_r <= 1'b0;
            err_r <= 1'b0;
            arbl_r <= 1'b0;
            fail_r <= 1'b0;
            addr_r <= '0;
            word_r <= '0;
            valid_r <= 1'b0;
            act_r <= 1'b0;
        end else if (CE) begin
            st_r <= st_nxt;
            lock_r <= lock_nxt;
            done_r <= done_nxt;
            err_r <= err_nxt;
            arbl_r <= arbl_nxt;
            fail_r <= fail_nxt;
            addr_r <= addr_nxt;
            word_r <= word_nxt;
            valid_r <= valid_nxt;
            act_r <= act_nxt;
        end
    end

    assign lnk.lock = lock_r && CE;
    assign lnk.unl_done = done_r && CE;
    assign lnk.unl_err = err_r && CE;
    assign lnk.unl_arbl = arbl_r && CE;
    assign lnk.unl_fail = fail_r && CE;
    assign lnk.rd_addr = addr_r;
    assign SLOT_VALID = valid_r;
    assign TX_ACTIVE = act_r;
    assign TX_WORD = word_r;
endmodule

// ### tfs_props.sv
// concurrent checks on the link between slot and protocol controller
`timescale 1ns/100ps
module tfs_props (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic avail,
    input wire logic lock,
    input wire logic unl_done,
    input wire logic unl_err,
    input wire logic unl_arbl,
    input wire logic unl_fail,
    input wire logic [tfs_pkg::RTC_W-1:0] rtc_cnt,
    input wire logic [tfs_pkg::RTC_W-1:0] rtc_lim,
    input wire logic rtc_en
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    // any controller command, and the two retry outcomes
    wire hw_cmd = lock | unl_done | unl_err | unl_arbl | unl_fail;
    wire retry = unl_err | unl_arbl;

    chk_lock_when_avail: assert property (lock |-> $past(avail))
        else $error("lock without an available slot");
    chk_lock_drops_avail: assert property (lock |-> ##[1:2] !avail)
        else $error("slot still available after lock");
    chk_cmd_onehot: assert property ($onehot0({lock, unl_done, unl_err, unl_arbl, unl_fail}))
        else $error("two link commands at once");
    chk_cmd_single: assert property (hw_cmd |=> !hw_cmd)
        else $error("link command longer than one cycle");
    chk_cnt_step: assert property ((rtc_cnt != 4'h0 && rtc_cnt != $past(rtc_cnt)) |->
        ($past(retry) && rtc_cnt == $past(rtc_cnt) + 4'h1))
        else $error("retry count moved without a retry");
    chk_fail_at_limit: assert property (unl_fail |-> rtc_en && rtc_cnt == rtc_lim)
        else $error("failed outcome below the limit");
    chk_retry_in_budget: assert property (retry |-> !(rtc_en && rtc_cnt == rtc_lim))
        else $error("retry issued with the limit reached");
    chk_retry_ready: assert property (retry ##1 (rtc_cnt != $past(rtc_cnt)) |-> ##[0:2] avail)
        else $error("slot not available again after retry");
endmodule

// ### testbench.sv
// self-checking bench: transmit slot and controller joined over the link
`timescale 1ns/100ps
module testbench;
    logic SYS_CLK, RST_N, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, TX_WORD, q;
    logic LOCK_WINDOW, FRAME_DONE, FRAME_ERR, ARB_LOST, NEXT_WORD, SLOT_VALID, TX_ACTIVE;
    logic [2:0] SLOT_STATE;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    // row layout: bit7 abort in flight, 5:4 outcome, bit3 retry count, 2:0 final state
    logic [7:0] rows [6] = '{8'h04, 8'h19, 8'h29, 8'h84, 8'h95, 8'ha5};

    tfs_link_if lnk ();
    tfs_slot i_tfs_slot (.SYS_CLK, .RST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .SLOT_STATE, .lnk(lnk));
    tfs_ctl i_tfs_ctl (.SYS_CLK, .RST_N, .CE, .LOCK_WINDOW, .FRAME_DONE, .FRAME_ERR, .ARB_LOST,
        .NEXT_WORD, .SLOT_VALID, .TX_ACTIVE, .TX_WORD, .lnk(lnk));
    tfs_props i_tfs_props (.SYS_CLK, .RST_N, .avail(lnk.avail), .lock(lnk.lock),
        .unl_done(lnk.unl_done), .unl_err(lnk.unl_err), .unl_arbl(lnk.unl_arbl),
        .unl_fail(lnk.unl_fail), .rtc_cnt(lnk.rtc_cnt), .rtc_lim(lnk.rtc_lim),
        .rtc_en(lnk.rtc_en));

    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // compare one value
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer, read data to q and error flag to err
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'h1;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'h1 && n < 20);
        q = PRDATA;
        err = PSLVERR;
        if (n == 20) miscompares++;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge SYS_CLK);
    endtask

    // software command, then let availability settle
    task automatic cmd(input int b);
        apb(1'h1, tfs_pkg::OFF_CMD, 32'h1 << b);
        repeat (2) @(posedge SYS_CLK);
    endtask

    // open the lock window until transmission starts
    task automatic go_tx();
        int n;
        n = 0;
        LOCK_WINDOW <= 1'h1;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (TX_ACTIVE !== 1'h1 && n < 20);
        LOCK_WINDOW <= 1'h0;
        repeat (2) @(posedge SYS_CLK);
        chk("tx", SLOT_STATE, 32'h2);
    endtask

    // one frame outcome pulse: 0 done, 1 error, 2 arbitration lost
    task automatic pulse(input logic [1:0] k);
        FRAME_DONE <= (k == 2'h0);
        FRAME_ERR <= (k == 2'h1);
        ARB_LOST <= (k == 2'h2);
        @(posedge SYS_CLK);
        {FRAME_DONE, FRAME_ERR, ARB_LOST} <= 3'h0;
        repeat (3) @(posedge SYS_CLK);
    endtask

    // clock and hang guard
    initial begin
        SYS_CLK = 1'h0;
        forever #2 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        {RST_N, PSEL, PENABLE, PWRITE, LOCK_WINDOW, FRAME_DONE, FRAME_ERR, ARB_LOST} = '0;
        NEXT_WORD = 1'h0;
        CE = 1'h1;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        repeat (6) @(posedge SYS_CLK);
        RST_N <= 1'h1;
        @(posedge SYS_CLK);
        chk("rst state", SLOT_STATE, 32'h0);
        apb(1'h0, tfs_pkg::OFF_CFG, 32'h0);
        chk("rst cfg", q, 32'h0);
        apb(1'h0, 8'h20, 32'h0);
        chk("slverr", err, 32'h1);
        apb(1'h1, tfs_pkg::OFF_MEM, 32'h1234abcd);
        // ready, lock, optional abort, outcome, then clean up
        for (int i = 0; i < 6; i++) begin
            cmd(tfs_pkg::CMD_READY);
            chk("ready", SLOT_STATE, 32'h1);
            chk("valid", SLOT_VALID, 32'h1);
            if (i == 0) apb(1'h1, tfs_pkg::OFF_MEM, 32'h55aa55aa);
            go_tx();
            if (i == 0) begin
                NEXT_WORD <= 1'h1;
                @(posedge SYS_CLK);
                NEXT_WORD <= 1'h0;
                repeat (2) @(posedge SYS_CLK);
                chk("word", TX_WORD, 32'h1234abcd);
            end
            if (rows[i][7]) begin
                cmd(tfs_pkg::CMD_ABORT);
                chk("pend", SLOT_STATE, 32'h3);
                chk("active", TX_ACTIVE, 32'h1);
            end
            pulse(rows[i][5:4]);
            chk("outcome", SLOT_STATE, {29'h0, rows[i][2:0]});
            apb(1'h0, tfs_pkg::OFF_STAT, 32'h0);
            chk("stat", q[2:0], {29'h0, rows[i][2:0]});
            chk("count", q[11:8], {31'h0, rows[i][3]});
            cmd(tfs_pkg::CMD_ABORT);
            chk("ignored", SLOT_STATE,
                (rows[i][2:0] == 3'h1) ? 32'h5 : {29'h0, rows[i][2:0]});
            cmd(tfs_pkg::CMD_EMPTY);
            chk("empty", SLOT_STATE, 32'h0);
        end
        // abort written in the very cycle of the lock pulse leaves the slot abort pending
        cmd(tfs_pkg::CMD_READY);
        fork
            apb(1'h1, tfs_pkg::OFF_CMD, 32'h2);
            begin
                @(posedge SYS_CLK);
                LOCK_WINDOW <= 1'h1;
                @(posedge SYS_CLK);
                LOCK_WINDOW <= 1'h0;
            end
        join
        chk("lock abort", SLOT_STATE, 32'h3);
        chk("lock tx", TX_ACTIVE, 32'h1);
        pulse(2'h1);
        chk("aborted", SLOT_STATE, 32'h5);
        cmd(tfs_pkg::CMD_EMPTY);
        // abort on a ready slot drops availability while the write completes
        cmd(tfs_pkg::CMD_READY);
        fork
            apb(1'h1, tfs_pkg::OFF_CMD, 32'h2);
            begin
                repeat (2) @(posedge SYS_CLK);
                #1;
                chk("drop", lnk.avail, 32'h0);
                chk("still", SLOT_STATE, 32'h1);
            end
        join
        chk("gone", SLOT_STATE, 32'h5);
        cmd(tfs_pkg::CMD_EMPTY);
        // limit of 2 enabled: two retries, then failure
        apb(1'h1, tfs_pkg::OFF_CFG, 32'h102);
        apb(1'h0, tfs_pkg::OFF_CFG, 32'h0);
        chk("cfg", q, 32'h102);
        cmd(tfs_pkg::CMD_READY);
        for (int k = 0; k < 3; k++) begin
            go_tx();
            pulse((k == 1) ? 2'h2 : 2'h1);
            chk("limit", SLOT_STATE, (k == 2) ? 32'h6 : 32'h1);
        end
        cmd(tfs_pkg::CMD_READY);
        apb(1'h0, tfs_pkg::OFF_STAT, 32'h0);
        chk("cleared", q, 32'h1);
        // clock enable low freezes both ends while the lock window is open
        CE <= 1'h0;
        LOCK_WINDOW <= 1'h1;
        repeat (3) @(posedge SYS_CLK);
        chk("frozen", TX_ACTIVE, 32'h0);
        chk("held", SLOT_STATE, 32'h1);
        CE <= 1'h1;
        go_tx();
        // reset in mid-transmission returns both ends to their reset values
        RST_N <= 1'h0;
        repeat (2) @(posedge SYS_CLK);
        RST_N <= 1'h1;
        @(posedge SYS_CLK);
        chk("rerst state", SLOT_STATE, 32'h0);
        chk("rerst tx", TX_ACTIVE, 32'h0);
        chk("rerst valid", SLOT_VALID, 32'h0);
        apb(1'h0, tfs_pkg::OFF_CFG, 32'h0);
        chk("rerst cfg", q, 32'h0);
        apb(1'h0, tfs_pkg::OFF_STAT, 32'h0);
        chk("rerst stat", q, 32'h0);
        finish_test();
    end
endmodule
